// File: src/ring_option_ctrl.v
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ring_option_regs.vh"

module ring_option_ctrl #(
  parameter SHORT_W = 16,
  parameter LONG_W = 48
) (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_addr_valid,
  input wire rx_long_addr,
  input wire [LONG_W-1:0] rx_dest_addr,
  input wire [LONG_W-1:0] rx_src_addr,
  input wire rx_group_match,
  input wire recovery_required,
  input wire claim_request,
  input wire claim_won,
  input wire higher_claim_or_beacon,
  input wire token_capture_req,
  input wire immediate_req,
  output reg addr_recognized_flag,
  output reg own_source_flag,
  output reg strip_frame,
  output reg enter_claim,
  output reg claim_tx_state,
  output reg issue_token,
  output reg repeat_enable,
  output reg token_capture_grant,
  output reg recovery_enable,
  output reg immediate_grant,
  output reg long_tx_permit,
  output reg short_tx_permit,
  output reg claim_beacon_use_long,
  output reg void_use_long
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg [`OPT_WIDTH-1:0] option_reg;
  reg [SHORT_W-1:0] own_short_address_reg;
  reg [LONG_W-1:0] my_long_address_reg;
  reg sa_transp_reg;
  reg hold_active_reg;

  wire short_en = option_reg[`OPT_BIT_SHORT_EN];
  wire long_en = option_reg[`OPT_BIT_LONG_EN];
  wire hold_tok = option_reg[`OPT_BIT_HOLD_TOKEN];
  wire inhibit_rec = option_reg[`OPT_BIT_INHIBIT_REC];
  wire ring_broken = ~short_en & ~long_en;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data park here until both are in; either may come first
  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_reg | aw_take;
  wire w_have = w_held_reg | w_take;
  wire [7:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_reg;
  wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_reg;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb_reg;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;

  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a == `OPT_ADDR_OPTION) || (a == `OPT_ADDR_SHORT_ADDR) ||
                    (a == `OPT_ADDR_LONG_ADDR_LO) || (a == `OPT_ADDR_LONG_ADDR_HI) ||
                    (a == `OPT_ADDR_SA_TRANSP) || (a == `OPT_ADDR_STATUS);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (s[k]) begin
          merge[k*8 +: 8] = d[k*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] long_hi_now = {{(64-LONG_W){1'b0}}, my_long_address_reg[LONG_W-1:32]};
  wire [31:0] opt_m = merge({28'h0000000, option_reg}, wr_data, wr_strb);
  wire [31:0] sa_m = merge({{(32-SHORT_W){1'b0}}, own_short_address_reg}, wr_data, wr_strb);
  wire [31:0] llo_m = merge(my_long_address_reg[31:0], wr_data, wr_strb);
  wire [31:0] lhi_m = merge(long_hi_now, wr_data, wr_strb);
  wire [31:0] tr_m = merge({31'h00000000, sa_transp_reg}, wr_data, wr_strb);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      option_reg <= `OPT_RESET;
      own_short_address_reg <= {SHORT_W{1'b0}};
      my_long_address_reg <= {LONG_W{1'b0}};
      sa_transp_reg <= 1'b0;
    end else begin
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
        case (wr_addr)
          `OPT_ADDR_OPTION: option_reg <= opt_m[`OPT_WIDTH-1:0];
          `OPT_ADDR_SHORT_ADDR: own_short_address_reg <= sa_m[SHORT_W-1:0];
          `OPT_ADDR_LONG_ADDR_LO: my_long_address_reg[31:0] <= llo_m;
          `OPT_ADDR_LONG_ADDR_HI: my_long_address_reg[LONG_W-1:32] <= lhi_m[LONG_W-33:0];
          `OPT_ADDR_SA_TRANSP: sa_transp_reg <= tr_m[0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Flag bits are one-cycle pulses; a polling read will usually see them low
  reg [31:0] status_word;
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_BIT_ADDR_REC] = addr_recognized_flag;
    status_word[`ST_BIT_OWN_SRC] = own_source_flag;
    status_word[`ST_BIT_STRIP] = strip_frame;
    status_word[`ST_BIT_RING_BROKEN] = ring_broken;
    status_word[`ST_BIT_CLAIM_STATE] = claim_tx_state;
    status_word[`ST_BIT_HOLDING] = hold_active_reg;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `OPT_ADDR_OPTION: s_axi_rdata <= {28'h0000000, option_reg};
          `OPT_ADDR_SHORT_ADDR: s_axi_rdata <= {{(32-SHORT_W){1'b0}}, own_short_address_reg};
          `OPT_ADDR_LONG_ADDR_LO: s_axi_rdata <= my_long_address_reg[31:0];
          `OPT_ADDR_LONG_ADDR_HI: s_axi_rdata <= long_hi_now;
          `OPT_ADDR_SA_TRANSP: s_axi_rdata <= {31'h00000000, sa_transp_reg};
          `OPT_ADDR_STATUS: s_axi_rdata <= status_word;
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Address recognition
  // ----------------------------------------------------------------
  // Short addresses sit in the low bits of the address buses
  wire long_ok = rx_addr_valid & rx_long_addr & long_en;
  wire short_ok = rx_addr_valid & ~rx_long_addr & short_en;
  wire dst_long_hit = long_ok & ((rx_dest_addr == my_long_address_reg) | rx_group_match);
  wire dst_short_hit = short_ok &
    ((rx_dest_addr[SHORT_W-1:0] == own_short_address_reg) | rx_group_match);
  wire src_long_hit = long_ok & (rx_src_addr == my_long_address_reg);
  wire src_short_hit = short_ok & (rx_src_addr[SHORT_W-1:0] == own_short_address_reg);

  // ----------------------------------------------------------------
  // Claim control
  // ----------------------------------------------------------------
  // A software claim ignores the inhibit; ring-detected recovery does not
  wire recov_claim = recovery_required & ~inhibit_rec & ~ring_broken;
  wire claim_go = claim_request | recov_claim;
  reg claim_tx_next;
  reg hold_active_next;

  // A new claim outranks a higher claim seen in the same cycle
  always @* begin
    claim_tx_next = claim_tx_state;
    hold_active_next = hold_active_reg;
    if (claim_go) begin
      claim_tx_next = 1'b1;
      hold_active_next = 1'b0;
    end else if (claim_tx_state & higher_claim_or_beacon) begin
      claim_tx_next = 1'b0;
      hold_active_next = 1'b0;
    end else if (claim_tx_state & claim_won) begin
      claim_tx_next = hold_tok;
      hold_active_next = hold_tok;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_recognized_flag <= 1'b0;
      own_source_flag <= 1'b0;
      strip_frame <= 1'b0;
      enter_claim <= 1'b0;
      claim_tx_state <= 1'b0;
      hold_active_reg <= 1'b0;
      issue_token <= 1'b0;
      repeat_enable <= 1'b0;
      token_capture_grant <= 1'b0;
      recovery_enable <= 1'b0;
      immediate_grant <= 1'b0;
      long_tx_permit <= 1'b0;
      short_tx_permit <= 1'b0;
      claim_beacon_use_long <= 1'b0;
      void_use_long <= 1'b0;
    end else begin
      addr_recognized_flag <= dst_long_hit | dst_short_hit;
      own_source_flag <= src_long_hit | src_short_hit;
      strip_frame <= src_long_hit | src_short_hit;
      enter_claim <= claim_go & ~claim_tx_state;
      claim_tx_state <= claim_tx_next;
      hold_active_reg <= hold_active_next;
      issue_token <= claim_tx_state & claim_won & ~hold_tok & ~claim_go &
                     ~higher_claim_or_beacon;
      repeat_enable <= ~ring_broken;
      token_capture_grant <= token_capture_req & ~ring_broken;
      recovery_enable <= ~inhibit_rec & ~ring_broken;
      immediate_grant <= immediate_req & (~ring_broken | sa_transp_reg);
      long_tx_permit <= long_en | sa_transp_reg;
      short_tx_permit <= short_en | sa_transp_reg;
      claim_beacon_use_long <= long_en;
      void_use_long <= ~short_en & long_en;
    end
  end

endmodule // ring_option_ctrl
`default_nettype wire

// File: src/ring_option_regs.vh
`ifndef RING_OPTION_REGS_VH
`define RING_OPTION_REGS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define OPT_ADDR_OPTION 8'h00
`define OPT_ADDR_SHORT_ADDR 8'h04
`define OPT_ADDR_LONG_ADDR_LO 8'h08
`define OPT_ADDR_LONG_ADDR_HI 8'h0C
`define OPT_ADDR_SA_TRANSP 8'h10
`define OPT_ADDR_STATUS 8'h14

// ----------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------
`define OPT_BIT_SHORT_EN 0
`define OPT_BIT_LONG_EN 1
`define OPT_BIT_HOLD_TOKEN 2
`define OPT_BIT_INHIBIT_REC 3
`define OPT_WIDTH 4
`define OPT_RESET 4'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_BIT_ADDR_REC 0
`define ST_BIT_OWN_SRC 1
`define ST_BIT_STRIP 2
`define ST_BIT_RING_BROKEN 3
`define ST_BIT_CLAIM_STATE 4
`define ST_BIT_HOLDING 5

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: tb/ring_option_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ring_option_chk (
  input wire clk,
  input wire rst,
  input wire rx_addr_valid,
  input wire recovery_required,
  input wire claim_request,
  input wire claim_won,
  input wire higher_claim_or_beacon,
  input wire enter_claim,
  input wire claim_tx_state,
  input wire issue_token,
  input wire repeat_enable,
  input wire token_capture_grant,
  input wire recovery_enable,
  input wire immediate_grant,
  input wire long_tx_permit,
  input wire short_tx_permit,
  input wire addr_recognized_flag,
  input wire own_source_flag,
  input wire strip_frame
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  property p_req; claim_request && !claim_tx_state |=> enter_claim && claim_tx_state; endproperty
  a_req: assert property (p_req) else $error("claim request ignored");
  property p_tok; issue_token |-> $past(claim_won) && !claim_tx_state; endproperty
  a_tok: assert property (p_tok) else $error("token without win");
  property p_hold; claim_tx_state && !claim_won && !higher_claim_or_beacon |=> claim_tx_state;
  endproperty
  a_hold: assert property (p_hold) else $error("claim state left early");
  property p_entry; $rose(claim_tx_state) |-> enter_claim; endproperty
  a_entry: assert property (p_entry) else $error("claim entry not flagged");
  property p_brk; !repeat_enable |-> !token_capture_grant && !recovery_enable; endproperty
  a_brk: assert property (p_brk) else $error("broken ring still active");
  property p_perm; !repeat_enable |-> long_tx_permit == short_tx_permit; endproperty
  a_perm: assert property (p_perm) else $error("permits differ");
  property p_imm; !repeat_enable && immediate_grant |-> short_tx_permit; endproperty
  a_imm: assert property (p_imm) else $error("immediate without transparency");
  property p_strip; own_source_flag |-> strip_frame; endproperty
  a_strip: assert property (p_strip) else $error("own frame not stripped");
  property p_flag; addr_recognized_flag || own_source_flag |-> $past(rx_addr_valid); endproperty
  a_flag: assert property (p_flag) else $error("flag without address");
  property p_pulse; enter_claim |=> !enter_claim; endproperty
  a_pulse: assert property (p_pulse) else $error("entry pulse too long");
  property p_inhib;
    recovery_required && !claim_request && !claim_tx_state ##1 !recovery_enable
      |-> !claim_tx_state;
  endproperty
  a_inhib: assert property (p_inhib) else $error("recovery claim not suppressed");
  property p_keep; claim_tx_state && claim_won ##1 claim_tx_state |-> !issue_token; endproperty
  a_keep: assert property (p_keep) else $error("token issued while holding");
  c_claim: cover property (enter_claim);
  c_hold: cover property (claim_tx_state && $past(claim_won));
  c_brk: cover property (!repeat_enable && immediate_grant);
  c_tok: cover property (issue_token);
endmodule // ring_option_chk
bind ring_option_ctrl ring_option_chk u_chk (
  .clk(clk),
  .rst(rst),
  .rx_addr_valid(rx_addr_valid),
  .recovery_required(recovery_required),
  .claim_request(claim_request),
  .claim_won(claim_won),
  .higher_claim_or_beacon(higher_claim_or_beacon),
  .enter_claim(enter_claim),
  .claim_tx_state(claim_tx_state),
  .issue_token(issue_token),
  .repeat_enable(repeat_enable),
  .token_capture_grant(token_capture_grant),
  .recovery_enable(recovery_enable),
  .immediate_grant(immediate_grant),
  .long_tx_permit(long_tx_permit),
  .short_tx_permit(short_tx_permit),
  .addr_recognized_flag(addr_recognized_flag),
  .own_source_flag(own_source_flag),
  .strip_frame(strip_frame)
);
`default_nettype wire

// File: tb/ring_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ring_peer (
  input wire clk,
  input wire logic [8:0] ev,
  input wire logic [47:0] da,
  input wire logic [47:0] sa,
  output logic [8:0] ring,
  output logic [47:0] dst,
  output logic [47:0] src
);
  initial begin
    ring = 9'h000;
    dst = 48'h0;
    src = 48'h0;
  end
  // Idle address lines toggle so stale values cannot pass for a match
  always @(posedge clk) begin
    ring <= ev;
    dst <= ev[8] ? da : ~dst;
    src <= ev[8] ? sa : ~src;
  end
endmodule // ring_peer
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ring_option_regs.vh"
module tb;
  logic clk = 0, rst = 1, smp = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [8:0] ev = 9'h000;
  logic [47:0] da = 48'h0, sa = 48'h0;
  wire [8:0] ring;
  wire [47:0] dst, src;
  wire [15:0] obs;
  logic [31:0] q[$], e;
  logic [33:0] rq[$], re;
  logic [1:0] bq[$], be;
  logic [15:0] r;
  int errors = 0, tests_run = 0;
  localparam logic [47:0] LA = 48'h456789ABCDEF;
  always #5 clk = ~clk;
  assign obs[1:0] = 2'h0;
  ring_peer u_peer (.clk(clk), .ev(ev), .da(da), .sa(sa), .ring(ring), .dst(dst), .src(src));
  ring_option_ctrl u_dut (.clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_dest_addr(dst), .rx_src_addr(src),
    .rx_addr_valid(ring[8]), .rx_long_addr(ring[7]), .rx_group_match(ring[6]),
    .recovery_required(ring[5]), .claim_request(ring[4]), .claim_won(ring[3]),
    .higher_claim_or_beacon(ring[2]), .token_capture_req(ring[1]), .immediate_req(ring[0]),
    .repeat_enable(obs[15]), .token_capture_grant(obs[14]), .recovery_enable(obs[13]),
    .immediate_grant(obs[12]), .long_tx_permit(obs[11]), .short_tx_permit(obs[10]),
    .claim_beacon_use_long(obs[9]), .void_use_long(obs[8]), .addr_recognized_flag(obs[7]),
    .own_source_flag(obs[6]), .strip_frame(obs[5]), .enter_claim(obs[4]),
    .claim_tx_state(obs[3]), .issue_token(obs[2]));
  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (smp) begin
      e = q.pop_front();
      tests_run++;
      if ((obs & e[31:16]) !== e[15:0]) begin
        errors++;
        $display("mismatch %0t ring outputs %h expected %h", $time, obs, e[15:0]);
      end
    end
    if (s_axi_bvalid === 1'h1 && s_axi_bready) begin
      be = bq.pop_front();
      tests_run++;
      if (s_axi_bresp !== be) begin
        errors++;
        $display("mismatch %0t write response %h", $time, s_axi_bresp);
      end
    end
    if (s_axi_rvalid === 1'h1 && s_axi_rready) begin
      re = rq.pop_front();
      tests_run++;
      if ({s_axi_rresp, s_axi_rdata} !== re) begin
        errors++;
        $display("mismatch %0t read %h", $time, s_axi_rdata);
      end
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    @(posedge clk);
    bq.push_back(x);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    @(posedge clk);
    rq.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 0;
  endtask
  // Peer registers the event, the block answers one cycle after that
  task automatic chk(input logic [8:0] v, input logic [15:0] m, input logic [15:0] x);
    ev <= v;
    q.push_back({m, x});
    @(posedge clk) ev <= 9'h000;
    @(posedge clk) smp <= 1;
    @(posedge clk) smp <= 0;
  endtask
  task final_report;
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    final_report;
  end
  initial begin
    void'($urandom(64));
    r = 16'($urandom);
    repeat (8) @(posedge clk);
    rst <= 0;
    wr(`OPT_ADDR_OPTION, 32'h0, `RESP_OKAY);
    chk(9'h023, 16'hF010, 16'h0000);
    wr(`OPT_ADDR_SA_TRANSP, 32'h1, `RESP_OKAY);
    chk(9'h001, 16'h1C00, 16'h1C00);
    wr(`OPT_ADDR_SA_TRANSP, 32'h0, `RESP_OKAY);
    wr(`OPT_ADDR_SHORT_ADDR, {16'h0, r}, `RESP_OKAY);
    wr(`OPT_ADDR_LONG_ADDR_LO, LA[31:0], `RESP_OKAY);
    wr(`OPT_ADDR_LONG_ADDR_HI, {16'h0, LA[47:32]}, `RESP_OKAY);
    wr(`OPT_ADDR_OPTION, 32'h1, `RESP_OKAY);
    chk(9'h003, 16'hEF00, 16'hE400);
    da <= {32'h0, r};
    sa <= {32'h0, ~r};
    chk(9'h100, 16'h00E0, 16'h0080);
    da <= {32'h0, ~r};
    chk(9'h140, 16'h00E0, 16'h0080);
    sa <= {32'h0, r};
    chk(9'h100, 16'h00E0, 16'h0060);
    wr(`OPT_ADDR_OPTION, 32'h2, `RESP_OKAY);
    da <= LA;
    sa <= 48'h1;
    chk(9'h180, 16'h0FE0, 16'h0B80);
    da <= 48'h1;
    sa <= LA;
    chk(9'h180, 16'h00E0, 16'h0060);
    da <= {32'h0, r};
    sa <= {32'h0, ~r};
    chk(9'h100, 16'h00E0, 16'h0000);
    wr(`OPT_ADDR_OPTION, 32'h3, `RESP_OKAY);
    chk(9'h000, 16'h0300, 16'h0200);
    wr(`OPT_ADDR_OPTION, 32'h9, `RESP_OKAY);
    chk(9'h020, 16'h0018, 16'h0000);
    chk(9'h010, 16'h0018, 16'h0018);
    chk(9'h004, 16'h0008, 16'h0000);
    wr(`OPT_ADDR_OPTION, 32'h5, `RESP_OKAY);
    chk(9'h010, 16'h0018, 16'h0018);
    chk(9'h008, 16'h000C, 16'h0008);
    rd(`OPT_ADDR_STATUS, {`RESP_OKAY, 32'h30});
    chk(9'h000, 16'h000C, 16'h0008);
    chk(9'h004, 16'h0008, 16'h0000);
    wr(`OPT_ADDR_OPTION, 32'h1, `RESP_OKAY);
    chk(9'h010, 16'h0018, 16'h0018);
    chk(9'h008, 16'h000C, 16'h0004);
    chk(9'h020, 16'h0018, 16'h0018);
    wr(`OPT_ADDR_STATUS, 32'h3F, `RESP_OKAY);
    wr(8'h40, 32'h5, `RESP_SLVERR);
    rd(`OPT_ADDR_OPTION, {`RESP_OKAY, 32'h1});
    rd(`OPT_ADDR_SHORT_ADDR, {`RESP_OKAY, 16'h0, r});
    rd(8'h40, {`RESP_SLVERR, 32'h0});
    rd(`OPT_ADDR_STATUS, {`RESP_OKAY, 32'h10});
    final_report;
  end
endmodule // tb
`default_nettype wire
